// >>> imd_decoder.sv
`timescale 1ns/1ns

// What this block does
// - map io registers and 64-bit view regions
// - map 48-bit view regions of sram0 and sram1; the other 48-bit regions are shadowed by 32-bit regions
// - map 32-bit view regions
// - map 16-bit view regions
// - core and io ports access independently
// - two core plus one io transfer per cycle
// - four operands per cycle in dual mode, instruction from cache
// - cache only fetches colliding with pm data
// - secondary element active only when enabled
// - dual mode moves two values per core port access; io port accesses stay single
// - three megabit sram, four megabit rom
module imd_decoder
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  input  wire logic [imd_pkg::NUM_PORTS-1:0]     acc_req,
  input  wire logic [imd_pkg::NUM_PORTS-1:0]     acc_we,
  input  wire logic [imd_pkg::NUM_PORTS-1:0][31:0] acc_addr,
  input  wire logic                              fetch_req,
  input  wire logic [31:0]                       fetch_addr,
  input  wire logic                              mode_we,
  input  wire logic                              secondary_element_enable,
  output logic      [imd_pkg::NUM_PORTS-1:0]     mem_en,
  output logic      [imd_pkg::NUM_PORTS-1:0]     mem_we,
  output imd_pkg::imd_kind_t [imd_pkg::NUM_PORTS-1:0] mem_kind,
  output logic      [imd_pkg::NUM_PORTS-1:0][1:0] mem_blk,
  output imd_pkg::imd_view_t [imd_pkg::NUM_PORTS-1:0] mem_view,
  output logic      [imd_pkg::NUM_PORTS-1:0][17:0] mem_idx,
  output logic      [imd_pkg::NUM_PORTS-1:0]     mem_pair,
  output logic                                   ioreg_en,
  output logic      [17:0]                       ioreg_idx,
  output logic                                   secondary_active,
  output logic                                   cache_fill,
  output logic      [31:0]                       cache_fill_addr
);

  // plain decode of one address; ranges never overlap inside one view
  function automatic imd_pkg::imd_dec_t decode(input logic [31:0] a);
    imd_pkg::imd_dec_t d;
    logic [31:0]       off;
    d      = '0;
    d.kind = imd_pkg::IMD_RESERVED;
    off    = '0;
    if (a <= imd_pkg::IOREG_HI)
    begin
      d.kind = imd_pkg::IMD_IOREG;
      d.idx  = a[17:0];
    end
    for (int r = 0; r < imd_pkg::NUM_REGIONS; r++)
    begin
      if (a >= imd_pkg::REGION_LO[r] && a <= imd_pkg::REGION_HI[r])
      begin
        off    = a - imd_pkg::REGION_LO[r];
        d.kind = imd_pkg::REGION_ROM[r % 6] ? imd_pkg::IMD_ROM : imd_pkg::IMD_SRAM;
        d.blk  = imd_pkg::REGION_BLK[r % 6];
        d.view = imd_pkg::imd_view_t'(2'(r / 6));
        d.idx  = off[17:0];
      end
    end
    return d;
  endfunction

  // bits one word of a view takes out of the block
  function automatic int view_bits(input imd_pkg::imd_view_t v);
    int w;
    w = 0;
    unique case (v)
      imd_pkg::IMD_LONG64:
      begin
        w = 64;
      end
      imd_pkg::IMD_EXT48:
      begin
        w = 48;
      end
      imd_pkg::IMD_NORM32:
      begin
        w = 32;
      end
      imd_pkg::IMD_SHORT16:
      begin
        w = 16;
      end
    endcase
    return w;
  endfunction

  // share of the on-chip totals behind one block
  function automatic int block_bits(input imd_pkg::imd_dec_t d);
    int b;
    b = 0;
    if (d.kind == imd_pkg::IMD_ROM)
    begin
      b = imd_pkg::ROM_BITS_BLK01;
    end
    else if (d.blk < 2'h2)
    begin
      b = imd_pkg::SRAM_BITS_BLK01;
    end
    else
    begin
      b = imd_pkg::SRAM_BITS_BLK23;
    end
    return b;
  endfunction

  // costs a multiplier per port, but a mistyped region end can never spill into the next block
  function automatic logic fits_block(input imd_pkg::imd_dec_t d);
    int used;
    used = (int'(d.idx) + 1) * view_bits(d.view);
    return used <= block_bits(d);
  endfunction

  // mode state: secondary element follows its enable bit
  logic next_secondary_active;

  always_comb
  begin
    next_secondary_active = secondary_active;
    if (mode_we)
    begin
      next_secondary_active = secondary_element_enable;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      secondary_active <= imd_pkg::MODE_SECONDARY_RST;
    end
    else if (ce)
    begin
      secondary_active <= next_secondary_active;
    end
  end

  // per-port decode; each port has its own path so none waits on another
  logic [imd_pkg::NUM_PORTS-1:0]                 next_mem_en;
  logic [imd_pkg::NUM_PORTS-1:0]                 next_mem_we;
  imd_pkg::imd_kind_t [imd_pkg::NUM_PORTS-1:0]   next_mem_kind;
  logic [imd_pkg::NUM_PORTS-1:0][1:0]            next_mem_blk;
  imd_pkg::imd_view_t [imd_pkg::NUM_PORTS-1:0]   next_mem_view;
  logic [imd_pkg::NUM_PORTS-1:0][17:0]           next_mem_idx;
  logic [imd_pkg::NUM_PORTS-1:0]                 next_mem_pair;
  logic                                          next_ioreg_en;
  logic [17:0]                                   next_ioreg_idx;
  imd_pkg::imd_dec_t [imd_pkg::NUM_PORTS-1:0]    dec;

  always_comb
  begin
    next_ioreg_en  = 1'b0;
    next_ioreg_idx = ioreg_idx;
    for (int p = 0; p < imd_pkg::NUM_PORTS; p++)
    begin
      dec[p]           = decode(acc_addr[p]);
      next_mem_kind[p] = dec[p].kind;
      next_mem_blk[p]  = dec[p].blk;
      next_mem_view[p] = dec[p].view;
      next_mem_idx[p]  = dec[p].idx;
      // only storage regions reach the arrays; rom and reserved take no write
      next_mem_en[p]   = acc_req[p] && (dec[p].kind == imd_pkg::IMD_ROM ||
                                        dec[p].kind == imd_pkg::IMD_SRAM) &&
                         fits_block(dec[p]);
      next_mem_we[p]   = next_mem_en[p] && acc_we[p] &&
                         dec[p].kind == imd_pkg::IMD_SRAM;
      // core buses move a second value for the secondary element
      next_mem_pair[p] = next_mem_en[p] && secondary_active &&
                         p != imd_pkg::PORT_IO;
    end
    // io registers are reached from the io port only
    if (acc_req[imd_pkg::PORT_IO] && dec[imd_pkg::PORT_IO].kind == imd_pkg::IMD_IOREG)
    begin
      next_ioreg_en  = 1'b1;
      next_ioreg_idx = dec[imd_pkg::PORT_IO].idx;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_en    <= '0;
      mem_we    <= '0;
      mem_kind  <= '{default: imd_pkg::IMD_RESERVED};
      mem_blk   <= '0;
      mem_view  <= '{default: imd_pkg::IMD_LONG64};
      mem_idx   <= '0;
      mem_pair  <= '0;
      ioreg_en  <= 1'b0;
      ioreg_idx <= '0;
    end
    else if (ce)
    begin
      mem_en    <= next_mem_en;
      mem_we    <= next_mem_we;
      mem_kind  <= next_mem_kind;
      mem_blk   <= next_mem_blk;
      mem_view  <= next_mem_view;
      mem_idx   <= next_mem_idx;
      mem_pair  <= next_mem_pair;
      ioreg_en  <= next_ioreg_en;
      ioreg_idx <= next_ioreg_idx;
    end
  end

  // selective cache fill: a fetch that lost the pm bus to data is cached
  logic        next_cache_fill;
  logic [31:0] next_cache_fill_addr;

  always_comb
  begin
    next_cache_fill      = fetch_req && acc_req[imd_pkg::PORT_PM];
    next_cache_fill_addr = next_cache_fill ? fetch_addr : cache_fill_addr;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cache_fill      <= 1'b0;
      cache_fill_addr <= '0;
    end
    else if (ce)
    begin
      cache_fill      <= next_cache_fill;
      cache_fill_addr <= next_cache_fill_addr;
    end
  end

endmodule

// >>> imd_pkg.sv
package imd_pkg;

  // access kinds seen by the storage side
  typedef enum logic [1:0]
  {
    IMD_RESERVED = 2'b00,
    IMD_IOREG    = 2'b01,
    IMD_ROM      = 2'b10,
    IMD_SRAM     = 2'b11
  } imd_kind_t;

  // word width views of the same storage
  typedef enum logic [1:0]
  {
    IMD_LONG64  = 2'b00,
    IMD_EXT48   = 2'b01,
    IMD_NORM32  = 2'b10,
    IMD_SHORT16 = 2'b11
  } imd_view_t;

  typedef struct packed
  {
    imd_kind_t   kind;
    logic [1:0]  blk;
    imd_view_t   view;
    logic [17:0] idx;
  } imd_dec_t;

  localparam int          NUM_PORTS = 3;
  localparam int          PORT_DM   = 0;
  localparam int          PORT_PM   = 1;
  localparam int          PORT_IO   = 2;
  localparam int          NUM_REGIONS = 24;
  localparam logic [31:0] IOREG_LO  = 32'h0000_0000;
  localparam logic [31:0] IOREG_HI  = 32'h0003_FFFF;

  // storage totals, split per block
  localparam int SRAM_BITS_TOTAL = 3 * 1024 * 1024;
  localparam int ROM_BITS_TOTAL  = 4 * 1024 * 1024;
  localparam int SRAM_BITS_BLK01 = 1024 * 1024;
  localparam int SRAM_BITS_BLK23 = 512 * 1024;
  localparam int ROM_BITS_BLK01  = 2 * 1024 * 1024;

  // region table: order is rom0, sram0, rom1, sram1, sram2, sram3 per view
  localparam logic [31:0] REGION_LO [NUM_REGIONS] = '{
    32'h0004_0000, 32'h0004_C000, 32'h0005_0000, 32'h0005_C000, 32'h0006_0000, 32'h0007_0000,
    32'h0008_0000, 32'h0009_0000, 32'h000A_0000, 32'h000B_0000, 32'h000C_0000, 32'h000E_0000,
    32'h0008_0000, 32'h0009_8000, 32'h000A_0000, 32'h000B_8000, 32'h000C_0000, 32'h000E_0000,
    32'h0010_0000, 32'h0013_0000, 32'h0014_0000, 32'h0017_0000, 32'h0018_0000, 32'h001C_0000
  };
  localparam logic [31:0] REGION_HI [NUM_REGIONS] = '{
    32'h0004_7FFF, 32'h0004_FFFF, 32'h0005_7FFF, 32'h0005_FFFF, 32'h0006_1FFF, 32'h0007_1FFF,
    32'h0008_AAA9, 32'h0009_5554, 32'h000A_AAA9, 32'h000B_5554, 32'h000C_2AA9, 32'h000E_2AA9,
    32'h0008_FFFF, 32'h0009_FFFF, 32'h000A_FFFF, 32'h000B_FFFF, 32'h000C_3FFF, 32'h000E_3FFF,
    32'h0011_FFFF, 32'h0013_FFFF, 32'h0015_FFFF, 32'h0017_FFFF, 32'h0018_7FFF, 32'h001C_7FFF
  };
  localparam logic [1:0] REGION_BLK [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  localparam logic       REGION_ROM [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  localparam logic       MODE_SECONDARY_RST = 1'b0;

endpackage

// >>> imd_chk.sv
`timescale 1ns/1ns
module imd_chk
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic [2:0]        acc_req,
  input wire logic [2:0][31:0]  acc_addr,
  input wire logic              fetch_req,
  input wire logic              mode_we,
  input wire logic              secondary_element_enable,
  input wire logic [2:0]        mem_en,
  input wire logic [2:0]        mem_pair,
  input wire logic              ioreg_en,
  input wire logic              secondary_active,
  input wire logic              cache_fill
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  req_gate_a: assert property (ce && !acc_req[1] |=> !mem_en[1])
    else $error("enable without request");
  resv_top_a: assert property (ce && acc_req[0] && acc_addr[0][31:21] != '0 |=> !mem_en[0])
    else $error("reserved space enabled");
  ioreg_hit_a: assert property (ce && acc_req[2] && acc_addr[2][31:18] == '0 |=> ioreg_en)
    else $error("io register missed");
  fill_hit_a: assert property (ce && fetch_req && acc_req[1] |=> cache_fill)
    else $error("conflict not cached");
  fill_skip_a: assert property (ce && !(fetch_req && acc_req[1]) |=> !cache_fill)
    else $error("fetch cached without conflict");
  mode_load_a: assert property (ce && mode_we |=>
    secondary_active == $past(secondary_element_enable)) else $error("mode not loaded");
  io_single_a: assert property (!mem_pair[2])
    else $error("io access paired");
  pair_off_a: assert property (ce && !secondary_active |=> mem_pair[1:0] == 2'b00)
    else $error("paired while single");
  ce_hold_a: assert property (!ce |=> $stable(mem_en) && $stable(secondary_active))
    else $error("state moved while enable low");
endmodule
bind imd_decoder imd_chk u_chk (.*);

// >>> imd_partner.sv
`timescale 1ns/1ns
module imd_partner
(
  input  wire logic         clk,
  output logic [2:0]        acc_req,
  output logic [2:0]        acc_we,
  output logic [2:0][31:0]  acc_addr,
  output logic              fetch_req,
  output logic [31:0]       fetch_addr
);
  initial
  begin
    acc_req = '0;
    acc_we = '0;
    acc_addr = '0;
    fetch_req = 1'b0;
    fetch_addr = '0;
  end
  // one cycle per request: these buses have no wait handshake
  task automatic send(input logic [2:0] r, input logic [2:0] w, input logic [2:0][31:0] a,
                      input logic f);
    @(posedge clk);
    acc_req <= r;
    acc_we <= w;
    acc_addr <= a;
    fetch_req <= f;
    fetch_addr <= a[1] ^ 32'h0000_0100;
    @(posedge clk);
    acc_req <= '0;
    fetch_req <= 1'b0;
    // released lines carry the inverse so a stale address never looks valid
    acc_addr <= ~a;
    fetch_addr <= ~(a[1] ^ 32'h0000_0100);
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam imd_pkg::imd_kind_t RS = imd_pkg::IMD_RESERVED, IO = imd_pkg::IMD_IOREG;
  localparam imd_pkg::imd_kind_t RO = imd_pkg::IMD_ROM, SR = imd_pkg::IMD_SRAM;
  localparam imd_pkg::imd_view_t V64 = imd_pkg::IMD_LONG64, V48 = imd_pkg::IMD_EXT48;
  localparam imd_pkg::imd_view_t V32 = imd_pkg::IMD_NORM32, V16 = imd_pkg::IMD_SHORT16;
  logic                      clk, rst, ce, mode_we, secondary_element_enable, fetch_req;
  logic [2:0]                acc_req, acc_we, mem_en, mem_we, mem_pair;
  logic [2:0][31:0]          acc_addr;
  logic [31:0]               fetch_addr, cache_fill_addr;
  logic [2:0][1:0]           mem_blk;
  logic [2:0][17:0]          mem_idx;
  logic [17:0]               ioreg_idx;
  logic                      ioreg_en, secondary_active, cache_fill;
  imd_pkg::imd_kind_t [2:0]  mem_kind;
  imd_pkg::imd_view_t [2:0]  mem_view;
  int                        n_fail, checks_done, cyc;
  imd_decoder uut (.*);
  imd_partner u_far (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      summarize;
    end
  end
  task automatic ck(input bit ok, input string m);
    checks_done++;
    if (!ok)
    begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic dec(input int p, input logic w, input logic [31:0] a, input imd_pkg::imd_kind_t k,
                     input logic [1:0] b, input imd_pkg::imd_view_t v, input logic [17:0] i);
    logic [2:0][31:0] aa;
    logic st;
    aa = '0;
    aa[p] = a;
    st = (k == RO) || (k == SR);
    u_far.send(3'b001 << p, {3{w}}, aa, 1'b0);
    #1;
    ck(mem_kind[p] === k && mem_en[p] === st && mem_we[p] === (w && k == SR), "kind");
    if (st)
    begin
      ck({mem_blk[p], mem_view[p], mem_idx[p]} === {b, v, i}, "place");
    end
  endtask
  task automatic set_mode(input logic v);
    @(posedge clk);
    mode_we <= 1'b1;
    secondary_element_enable <= v;
    @(posedge clk);
    mode_we <= 1'b0;
    #1;
    ck(secondary_active === v, "mode state");
  endtask
  task automatic t_map;
    dec(0, 1'b0, 32'h0004_7FFF, RO, 2'h0, V64, 18'h07FFF);
    dec(1, 1'b0, 32'h0007_1FFF, SR, 2'h3, V64, 18'h01FFF);
    dec(0, 1'b0, 32'h0009_5554, SR, 2'h0, V48, 18'h05554);
    dec(1, 1'b0, 32'h000B_0000, SR, 2'h1, V48, 18'h00000);
    dec(0, 1'b1, 32'h0009_8004, SR, 2'h0, V32, 18'h00004);
    dec(1, 1'b0, 32'h000C_3FFF, SR, 2'h2, V32, 18'h03FFF);
    dec(0, 1'b0, 32'h0011_FFFF, RO, 2'h0, V16, 18'h1FFFF);
    dec(1, 1'b1, 32'h001C_7FFF, SR, 2'h3, V16, 18'h07FFF);
  endtask
  task automatic t_refuse;
    dec(0, 1'b1, 32'h0007_2000, RS, 2'h0, V64, 18'h0);
    dec(1, 1'b0, 32'h0009_5555, RS, 2'h0, V64, 18'h0);
    dec(0, 1'b1, 32'h0020_0000, RS, 2'h0, V64, 18'h0);
    dec(1, 1'b1, 32'h0014_0000, RO, 2'h1, V16, 18'h0);
    dec(0, 1'b0, 32'h0000_0010, IO, 2'h0, V64, 18'h0);
    ck(ioreg_en === 1'b0, "core reached io regs");
    dec(2, 1'b0, 32'h0003_FFFF, IO, 2'h0, V64, 18'h0);
    ck(ioreg_en === 1'b1 && ioreg_idx === 18'h3FFFF, "io register");
  endtask
  task automatic t_ports;
    u_far.send(3'b111, 3'b100, {32'h0009_8010, 32'h0005_C020, 32'h0009_8030}, 1'b0);
    #1;
    ck(mem_en === 3'b111 && mem_we === 3'b100, "three transfers");
    ck(mem_idx[2] === 18'h00010 && mem_blk[1] === 2'h1, "io beside core");
    u_far.send(3'b000, 3'b000, {3{32'h0009_8000}}, 1'b1);
    #1;
    ck(cache_fill === 1'b0, "fill without conflict");
    u_far.send(3'b010, 3'b000, {3{32'h000B_8000}}, 1'b1);
    #1;
    ck(cache_fill === 1'b1 && cache_fill_addr === 32'h000B_8100, "fill on conflict");
  endtask
  task automatic t_dual;
    u_far.send(3'b011, 3'b000, {32'h0, 32'h0009_8000, 32'h000B_8000}, 1'b0);
    #1;
    ck(mem_pair === 3'b000, "pair while single");
    set_mode(1'b1);
    u_far.send(3'b111, 3'b000, {32'h0009_8000, 32'h0009_8000, 32'h000B_8000}, 1'b1);
    #1;
    ck(mem_pair === 3'b011 && mem_en === 3'b111 && cache_fill === 1'b1, "dual");
    set_mode(1'b0);
  endtask
  task automatic t_size;
    dec(0, 1'b0, 32'h0004_FFFF, SR, 2'h0, V64, 18'h03FFF);
    ck((int'(mem_idx[0]) + 1) * 64 == imd_pkg::SRAM_BITS_BLK01, "block 0 sram size");
    dec(1, 1'b0, 32'h0018_7FFF, SR, 2'h2, V16, 18'h07FFF);
    ck((int'(mem_idx[1]) + 1) * 16 == imd_pkg::SRAM_BITS_BLK23, "block 2 sram size");
    dec(0, 1'b0, 32'h0015_FFFF, RO, 2'h1, V16, 18'h1FFFF);
    ck((int'(mem_idx[0]) + 1) * 16 == imd_pkg::ROM_BITS_BLK01, "block 1 rom size");
  endtask
  task automatic t_hold;
    @(posedge clk);
    ce <= 1'b0;
    u_far.send(3'b011, 3'b011, {3{32'h0009_8000}}, 1'b1);
    #1;
    ck(mem_en === 3'b000 && mem_we === 3'b000 && cache_fill === 1'b0, "enable low");
    @(posedge clk);
    ce <= 1'b1;
  endtask
  task automatic summarize;
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    mode_we = 1'b0;
    secondary_element_enable = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_map;
    t_refuse;
    t_size;
    t_ports;
    t_hold;
    t_dual;
    summarize;
  end
endmodule
